/* common/qsf_pkg.sv */
// Constants and carrier types for the quad SPI queue, DMA, event and wake block
package qsf_pkg;

  // Register offsets
  localparam logic [5:0] QSF_OFS_DATA  = 6'h00;
  localparam logic [5:0] QSF_OFS_DMA   = 6'h1c;
  localparam logic [5:0] QSF_OFS_EVFL  = 6'h20;
  localparam logic [5:0] QSF_OFS_EVEN  = 6'h24;
  localparam logic [5:0] QSF_OFS_WKFL  = 6'h28;
  localparam logic [5:0] QSF_OFS_WKEN  = 6'h2c;
  localparam logic [5:0] QSF_OFS_STAT  = 6'h30;

  // Queue geometry
  localparam logic [5:0] QSF_DEPTH     = 6'h20;

  // queue_dma_control field positions
  localparam int QSF_B_RX_DMA_EN  = 31;
  localparam int QSF_B_RX_CNT     = 24;
  localparam int QSF_B_RX_CLEAR   = 23;
  localparam int QSF_B_RX_EN      = 22;
  localparam int QSF_B_RX_LEVEL   = 16;
  localparam int QSF_B_TX_DMA_EN  = 15;
  localparam int QSF_B_TX_CNT     = 8;
  localparam int QSF_B_TX_CLEAR   = 7;
  localparam int QSF_B_TX_EN      = 6;
  localparam int QSF_B_TX_LEVEL   = 0;

  // event_flags / event_interrupt_enables bit positions
  localparam int QSF_F_RX_UND     = 15;
  localparam int QSF_F_RX_OVR     = 14;
  localparam int QSF_F_TX_UND     = 13;
  localparam int QSF_F_TX_OVR     = 12;
  localparam int QSF_F_M_DONE     = 11;
  localparam int QSF_F_ABORT      = 9;
  localparam int QSF_F_FAULT      = 8;
  localparam int QSF_F_SSD        = 5;
  localparam int QSF_F_SSA        = 4;
  localparam int QSF_F_RX_FULL    = 3;
  localparam int QSF_F_RX_THRESH  = 2;
  localparam int QSF_F_TX_EMPTY   = 1;
  localparam int QSF_F_TX_THRESH  = 0;

  // wake_flags / wake_enables bit positions
  localparam int QSF_W_RX_FULL    = 3;
  localparam int QSF_W_RX_THRESH  = 2;
  localparam int QSF_W_TX_EMPTY   = 1;
  localparam int QSF_W_TX_THRESH  = 0;

  // Implemented bits and reset values
  localparam logic [15:0] QSF_EVT_MASK      = 16'hfb3f;
  localparam logic [15:0] QSF_RX_FLAG_MASK  = 16'hc00c;
  localparam logic [15:0] QSF_TX_FLAG_MASK  = 16'h3003;
  localparam logic [15:0] QSF_EVFL_RST      = 16'h0002;
  localparam logic [4:0]  QSF_TX_LEVEL_RST  = 5'h10;
  localparam logic [4:0]  QSF_RX_LEVEL_RST  = 5'h00;

  // Byte carried from the serial engine into the receive queue
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } qsf_byte_t;

endpackage

/* dv/qsf_assertions.sv */
// Concurrent checks on the ports of the queue, DMA, event and wake block
module qsf_chk
  import qsf_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        resetn,
  // Register port
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [5:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata_ff,
  // Engine side and requests
  input wire logic        mode_master,
  input wire logic        core_tx_req,
  input wire logic        core_xfer_start,
  input wire logic        core_xfer_done,
  input wire qsf_byte_t   core_tx_ff,
  input wire logic        rx_stall_ff,
  input wire logic        tx_stall_ff,
  input wire logic        dma_rx_req_ff,
  input wire logic        dma_tx_req_ff,
  input wire logic        irq_ff,
  input wire logic        wake_req_ff,
  input wire logic        busy_ff
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_dma_wr;
    reg_wr && reg_addr == QSF_OFS_DMA;
  endsequence
  sequence s_even_off;
    reg_wr && reg_addr == QSF_OFS_EVEN && reg_wdata[15:0] == 16'h0;
  endsequence
  sequence s_wken_off;
    reg_wr && reg_addr == QSF_OFS_WKEN && reg_wdata[3:0] == 4'h0;
  endsequence
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata_ff == 32'h0)
    else $error("read data not zero when idle");
  tx_served_a: assert property (core_tx_ff.valid |-> $past(core_tx_req))
    else $error("transmit byte without request");
  txdma_off_a: assert property (s_dma_wr ##0 !reg_wdata[15] |=> ##1 !dma_tx_req_ff)
    else $error("transmit request kept after disable");
  rxdma_off_a: assert property (s_dma_wr ##0 !reg_wdata[31] |=> ##1 !dma_rx_req_ff)
    else $error("receive request kept after disable");
  irq_mask_a: assert property (s_even_off |=> ##1 !irq_ff)
    else $error("interrupt with all enables off");
  wake_mask_a: assert property (s_wken_off |=> ##1 !wake_req_ff)
    else $error("wake with all enables off");
  rx_stall_a: assert property (rx_stall_ff |-> $past(mode_master) || $past(mode_master, 2))
    else $error("receive stall outside master mode");
  tx_stall_a: assert property (tx_stall_ff |-> $past(mode_master) || $past(mode_master, 2))
    else $error("transmit stall outside master mode");
  busy_start_a: assert property (mode_master && core_xfer_start && !core_xfer_done |=> ##1 busy_ff)
    else $error("busy not raised at start");
  busy_done_a: assert property (mode_master && core_xfer_done |=> ##1 !busy_ff)
    else $error("busy not dropped at end");
endmodule // qsf_chk

bind qsf_core qsf_chk i_chk (.core_clk(core_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .mode_master(mode_master),
  .core_tx_req(core_tx_req), .core_xfer_start(core_xfer_start), .core_xfer_done(core_xfer_done),
  .core_tx_ff(core_tx_ff), .rx_stall_ff(rx_stall_ff), .tx_stall_ff(tx_stall_ff), .dma_rx_req_ff(dma_rx_req_ff),
  .dma_tx_req_ff(dma_tx_req_ff), .irq_ff(irq_ff), .wake_req_ff(wake_req_ff), .busy_ff(busy_ff));

/* dv/qsf_core_tb_top.sv */
// Self-checking bench for the queue, DMA, event and wake block
module qsf_core_tb_top
  import qsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk, resetn, reg_wr, reg_rd, mode_master, multi_master_en, rd_seen;
  logic        core_tx_req, core_xfer_start, core_xfer_done, core_collision;
  logic        rx_stall_ff, tx_stall_ff, dma_rx_req_ff, dma_tx_req_ff, irq_ff, wake_req_ff, busy_ff;
  logic        ss_n_pin, sck_pin, mm_ss_n_pin;
  logic [5:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata_ff, seed, b;
  qsf_byte_t   core_rx, core_tx_ff;
  logic [31:0] rdq[$], mq[$], txq[$], rxb[$];
  int          fail_count = 0, compares = 0, cyc = 0;

  qsf_core i_dut (.core_clk(core_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .mode_master(mode_master), .multi_master_en(multi_master_en),
    .core_rx(core_rx), .core_tx_req(core_tx_req), .core_xfer_start(core_xfer_start), .core_xfer_done(core_xfer_done),
    .core_collision(core_collision), .core_tx_ff(core_tx_ff), .rx_stall_ff(rx_stall_ff), .tx_stall_ff(tx_stall_ff),
    .ss_n_pin(ss_n_pin), .sck_pin(sck_pin), .mm_ss_n_pin(mm_ss_n_pin), .dma_rx_req_ff(dma_rx_req_ff),
    .dma_tx_req_ff(dma_tx_req_ff), .irq_ff(irq_ff), .wake_req_ff(wake_req_ff), .busy_ff(busy_ff));
  qsf_peer i_peer (.ss_n_pin(ss_n_pin), .sck_pin(sck_pin), .mm_ss_n_pin(mm_ss_n_pin));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic lv(input string n, input logic s, input logic e);
    chk(n, {31'h0, s}, {31'h0, e});
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask

  // Expected value is queued here and compared by the monitor one cycle later
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    @(negedge core_clk);
    rdq.push_back(e & m);
    mq.push_back(m);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    reg_rd = 1'b0;
  endtask

  task automatic push(input logic [7:0] d);
    @(negedge core_clk);
    core_rx = '{valid: 1'b1, data: d};
    @(negedge core_clk);
    core_rx.valid = 1'b0;
  endtask

  task automatic pulse(ref logic s);
    @(negedge core_clk);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    rd_seen <= reg_rd;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  always @(negedge core_clk) begin
    if (rd_seen === 1'b1) chk("rdata", reg_rdata_ff & mq.pop_front(), rdq.pop_front());
    if (core_tx_ff.valid === 1'b1) chk("txbyte", {24'h0, core_tx_ff.data}, txq.size() > 0 ? txq.pop_front() : 'x);
  end

  initial begin
    {resetn, reg_wr, reg_rd, mode_master, multi_master_en} = '0;
    {core_tx_req, core_xfer_start, core_xfer_done, core_collision} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    core_rx = '0;
    seed = 32'hdd8c9168;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    resetn = 1'b1;
    tick(3);
    rd(QSF_OFS_DMA, 32'h10);
    rd(QSF_OFS_EVFL, 32'h2, 32'hfffe);
    rd(QSF_OFS_WKFL, 32'h0, 32'he);
    rd(QSF_OFS_STAT, 32'h0);
    rd(6'h3c, 32'h0);
    b = xs();
    wr(QSF_OFS_EVEN, b);
    rd(QSF_OFS_EVEN, b & {16'h0, QSF_EVT_MASK});
    wr(QSF_OFS_EVEN, 32'h0);
    wr(QSF_OFS_WKEN, b);
    rd(QSF_OFS_WKEN, b & 32'hf);
    wr(QSF_OFS_WKEN, 32'h0);
    $display("test registers done");
    wr(QSF_OFS_EVFL, 32'hffff);
    wr(QSF_OFS_DMA, 32'h8042);
    repeat (3) begin
      b = xs() & 32'hff;
      txq.push_back(b);
      wr(QSF_OFS_DATA, b);
    end
    push(8'h5a);
    rd(QSF_OFS_DMA, 32'h8342);
    wr(QSF_OFS_EVFL, 32'hffff);
    rd(QSF_OFS_EVFL, 32'h0);
    repeat (4) pulse(core_tx_req);
    rd(QSF_OFS_EVFL, 32'h2003);
    lv("txdma", dma_tx_req_ff, 1'b1);
    wr(QSF_OFS_DMA, 32'h42);
    tick(3);
    lv("txdma", dma_tx_req_ff, 1'b0);
    repeat (33) wr(QSF_OFS_DATA, xs() & 32'hff);
    rd(QSF_OFS_DMA, 32'h2042);
    rd(QSF_OFS_EVFL, 32'h3003);
    wr(QSF_OFS_DMA, 32'h2);
    wr(QSF_OFS_DMA, 32'h82);
    wr(QSF_OFS_DATA, 32'h33);
    rd(QSF_OFS_DMA, 32'h2);
    rd(QSF_OFS_EVFL, 32'h3, 32'hfffe);
    $display("test transmit done");
    wr(QSF_OFS_DMA, 32'h80410042);
    repeat (2) begin
      b = xs() & 32'hff;
      rxb.push_back(b);
      push(b[7:0]);
    end
    tick(3);
    lv("rxdma", dma_rx_req_ff, 1'b1);
    wr(QSF_OFS_DMA, 32'h00410042);
    tick(3);
    lv("rxdma", dma_rx_req_ff, 1'b0);
    rd(QSF_OFS_DMA, 32'h02410042);
    rd(QSF_OFS_DATA, rxb[0]);
    rd(QSF_OFS_DATA, rxb[1]);
    rd(QSF_OFS_DATA, 32'h0);
    rd(QSF_OFS_EVFL, 32'h8007);
    repeat (33) push(8'(xs()));
    rd(QSF_OFS_DMA, 32'h20410042);
    rd(QSF_OFS_EVFL, 32'hc00f);
    mode_master = 1'b1;
    tick(3);
    lv("rxstall", rx_stall_ff, 1'b1);
    lv("txstall", tx_stall_ff, 1'b1);
    mode_master = 1'b0;
    wr(QSF_OFS_DMA, 32'h00c10042);
    rd(QSF_OFS_DMA, 32'h00410042);
    rd(QSF_OFS_EVFL, 32'h3);
    $display("test receive done");
    rd(QSF_OFS_WKFL, 32'hf);
    wr(QSF_OFS_WKEN, 32'h1);
    tick(3);
    lv("wake", wake_req_ff, 1'b1);
    wr(QSF_OFS_WKFL, 32'hf);
    rd(QSF_OFS_WKFL, 32'h1);
    wr(QSF_OFS_WKEN, 32'h2);
    tick(3);
    lv("wake", wake_req_ff, 1'b0);
    wr(QSF_OFS_EVEN, 32'h2);
    tick(3);
    lv("irq", irq_ff, 1'b1);
    wr(QSF_OFS_EVFL, 32'h2);
    tick(3);
    lv("irq", irq_ff, 1'b0);
    wr(QSF_OFS_EVEN, 32'h0);
    $display("test wake and interrupt done");
    wr(QSF_OFS_EVFL, 32'hffff);
    fork
      i_peer.frame(8);
      begin
        tick(100);
        lv("busy", busy_ff, 1'b1);
      end
    join
    rd(QSF_OFS_EVFL, 32'h31);
    rd(QSF_OFS_STAT, 32'h0);
    wr(QSF_OFS_EVFL, 32'hffff);
    i_peer.frame(3);
    rd(QSF_OFS_EVFL, 32'h231);
    mode_master = 1'b1;
    multi_master_en = 1'b1;
    wr(QSF_OFS_EVFL, 32'hffff);
    i_peer.foreign();
    rd(QSF_OFS_EVFL, 32'h101);
    wr(QSF_OFS_EVFL, 32'hffff);
    pulse(core_collision);
    rd(QSF_OFS_EVFL, 32'h101);
    pulse(core_xfer_start);
    rd(QSF_OFS_STAT, 32'h1);
    pulse(core_xfer_done);
    rd(QSF_OFS_STAT, 32'h0);
    rd(QSF_OFS_EVFL, 32'h901);
    tick(3);
    $display("test pins and master done");
    tally_and_finish();
  end
endmodule // qsf_core_tb_top

/* dv/qsf_peer.sv */
// Model of the external SPI master that drives slave select and serial clock
module qsf_peer (
  // Pins toward the port
  output logic ss_n_pin,
  output logic sck_pin,
  output logic mm_ss_n_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    ss_n_pin    = 1'b1;
    sck_pin     = 1'b0;
    mm_ss_n_pin = 1'b1;
  end
  // Select, clock n bits at 125 ns, release; the clock idles low between frames
  task automatic frame(input int n);
    ss_n_pin = 1'b0;
    #250;
    repeat (n) begin
      sck_pin = 1'b1;
      #62.5;
      sck_pin = 1'b0;
      #62.5;
    end
    ss_n_pin = 1'b1;
    #400;
  endtask
  // A second master asserting its select toward the port
  task automatic foreign();
    mm_ss_n_pin = 1'b0;
    #300;
    mm_ss_n_pin = 1'b1;
    #300;
  endtask
endmodule // qsf_peer

/* hw/qsf_core.sv */
// Queue, DMA request, event flag, wake and activity status logic of the quad SPI port
// Function
// - Receive count field reads the number of bytes held in the receive queue.
// - Writing one to receive clear empties receive queue and its flags.
// - Receive queue accepts bytes only while its enable bit is one.
// - Receive DMA request while receive count exceeds receive level; level 31 reserved.
// - Transmit DMA enable gates transmit requests; clearing it drops pending request.
// - Transmit count field reads the number of bytes waiting in transmit queue.
// - Setting transmit clear empties the transmit queue and its flags, but sets transmit empty if the queue held bytes.
// - Transmit queue operates only while its enable bit is one.
// - Transmit threshold flag and DMA request while count below level, reset 0x10.
// - Reading an empty receive queue sets receive underrun.
// - Slave: push into full receive queue sets overrun; master stalls instead.
// - Slave: transmit need on empty queue sets underrun; master stalls instead.
// - Software write into a full transmit queue sets transmit overrun.
// - Master mode: set master-finished flag when all transactions completed.
// - Slave mode: slave select released mid-character sets the abort flag.
// - Master with multi-master: foreign slave select sets fault; collision sets fault in any mode.
// - Sticky flags record slave select assertion and deassertion; write one clears.
// - Receive threshold flag set when receive count exceeds receive level.
// - Each event flag has an interrupt enable at the same bit position.
// - Four sticky wake flags in bits 3..0; write one clears each.
// - Wake request only for wake flags whose enable bit is one.
// - Busy: master from start to last character; slave follows slave select.
// - Receive DMA enable gates receive requests; clearing it drops pending request.
// - Master-mode input selects master when one, slave when zero.
module qsf_core
  import qsf_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata_ff,
  // Serial engine side
  input  wire logic        mode_master,
  input  wire logic        multi_master_en,
  input  wire qsf_byte_t   core_rx,
  input  wire logic        core_tx_req,
  input  wire logic        core_xfer_start,
  input  wire logic        core_xfer_done,
  input  wire logic        core_collision,
  output qsf_byte_t        core_tx_ff,
  output logic             rx_stall_ff,
  output logic             tx_stall_ff,
  // Pins
  input  wire logic        ss_n_pin,
  input  wire logic        sck_pin,
  input  wire logic        mm_ss_n_pin,
  // System requests
  output logic             dma_rx_req_ff,
  output logic             dma_tx_req_ff,
  output logic             irq_ff,
  output logic             wake_req_ff,
  output logic             busy_ff
);

  function automatic logic [5:0] qsf_cnt_next(input logic [5:0] cnt, input logic push, input logic pop);
    case ({push, pop})
      2'b10:   return cnt + 6'h01;
      2'b01:   return cnt - 6'h01;
      default: return cnt;
    endcase
  endfunction

  // Queue pointer step; a queue clear rewinds it to the first slot
  function automatic logic [4:0] qsf_ptr_next(input logic [4:0] ptr, input logic clr, input logic step);
    if (clr) begin
      return 5'h00;
    end
    return step ? 5'(ptr + 5'h01) : ptr;
  endfunction

  // Register strobe aimed at one offset
  function automatic logic qsf_hit(input logic stb, input logic [5:0] addr, input logic [5:0] ofs);
    return stb && (addr == ofs);
  endfunction

  // Whole-word mask applied only when its condition holds
  function automatic logic [15:0] qsf_sel16(input logic cond, input logic [15:0] mask);
    return cond ? mask : 16'h0000;
  endfunction

  // Reset release
  logic rst_meta_n_ff;
  logic rst_n_ff;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_n_ff <= 1'b0;
      rst_n_ff      <= 1'b0;
    end else begin
      rst_meta_n_ff <= 1'b1;
      rst_n_ff      <= rst_meta_n_ff;
    end
  end

  // Pin synchronisers and edge history
  logic [2:0] pin_meta_ff;
  logic [2:0] pin_sync_ff;
  logic       ss_act_d_ff;
  logic       sck_d_ff;
  logic       ss_act;
  logic       mm_ss_act;
  logic       sck_s;

  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      // Selects idle high and the serial clock idles low, so no false edge follows reset
      pin_meta_ff <= 3'h5;
      pin_sync_ff <= 3'h5;
      ss_act_d_ff <= 1'b0;
      sck_d_ff    <= 1'b0;
    end else begin
      pin_meta_ff <= {mm_ss_n_pin, sck_pin, ss_n_pin};
      pin_sync_ff <= pin_meta_ff;
      ss_act_d_ff <= ss_act;
      sck_d_ff    <= sck_s;
    end
  end

  assign ss_act    = ~pin_sync_ff[0];
  assign sck_s     = pin_sync_ff[1];
  assign mm_ss_act = ~pin_sync_ff[2];

  // Queue storage
  logic [7:0] rx_mem [32];
  logic [7:0] tx_mem [32];

  // Control state
  logic [4:0]  rx_wptr_ff, rx_rptr_ff, tx_wptr_ff, tx_rptr_ff;
  logic [5:0]  rx_cnt_ff, tx_cnt_ff;
  logic        rx_dma_en_ff, rx_en_ff, tx_dma_en_ff, tx_en_ff;
  logic [4:0]  rx_level_ff, tx_level_ff;
  logic [15:0] evfl_ff, even_ff;
  logic [3:0]  wkfl_ff, wken_ff;
  logic [2:0]  bit_cnt_ff;
  logic        mbusy_ff;

  logic [4:0]  nxt_rx_wptr, nxt_rx_rptr, nxt_tx_wptr, nxt_tx_rptr;
  logic [5:0]  nxt_rx_cnt, nxt_tx_cnt;
  logic        nxt_rx_dma_en, nxt_rx_en, nxt_tx_dma_en, nxt_tx_en;
  logic [4:0]  nxt_rx_level, nxt_tx_level;
  logic [15:0] nxt_evfl, nxt_even;
  logic [3:0]  nxt_wkfl, nxt_wken;
  logic [2:0]  nxt_bit_cnt;
  logic        nxt_mbusy;
  logic [31:0] nxt_reg_rdata;
  qsf_byte_t   nxt_core_tx;
  logic        nxt_rx_stall, nxt_tx_stall, nxt_dma_rx_req, nxt_dma_tx_req;
  logic        nxt_irq, nxt_wake_req, nxt_busy;

  // Decoded strobes
  logic        wr_dma, wr_evfl, wr_even, wr_wkfl, wr_wken, wr_data, rd_data;
  logic        rx_clear, tx_clear;
  logic        rx_push, rx_pop, tx_push, tx_pop;
  logic        rx_full, rx_empty, tx_full, tx_empty;
  logic        rx_thr, tx_thr, ss_rise, ss_fall, sck_rise;
  logic [15:0] ev_set, ev_clr;
  logic [3:0]  wk_set;

  always_comb begin
    wr_dma   = qsf_hit(reg_wr, reg_addr, QSF_OFS_DMA);
    wr_evfl  = qsf_hit(reg_wr, reg_addr, QSF_OFS_EVFL);
    wr_even  = qsf_hit(reg_wr, reg_addr, QSF_OFS_EVEN);
    wr_wkfl  = qsf_hit(reg_wr, reg_addr, QSF_OFS_WKFL);
    wr_wken  = qsf_hit(reg_wr, reg_addr, QSF_OFS_WKEN);
    wr_data  = qsf_hit(reg_wr, reg_addr, QSF_OFS_DATA);
    rd_data  = qsf_hit(reg_rd, reg_addr, QSF_OFS_DATA);
    // Clear bits act only in the write cycle and read back as zero
    rx_clear = wr_dma && reg_wdata[QSF_B_RX_CLEAR];
    tx_clear = wr_dma && reg_wdata[QSF_B_TX_CLEAR];

    rx_full  = (rx_cnt_ff == QSF_DEPTH);
    rx_empty = (rx_cnt_ff == 6'h00);
    tx_full  = (tx_cnt_ff == QSF_DEPTH);
    tx_empty = (tx_cnt_ff == 6'h00);

    rx_push  = core_rx.valid && rx_en_ff && !rx_full && !rx_clear;
    rx_pop   = rd_data && !rx_empty && !rx_clear;
    tx_push  = wr_data && tx_en_ff && !tx_full && !tx_clear;
    tx_pop   = core_tx_req && tx_en_ff && !tx_empty && !tx_clear;

    ss_rise  = ss_act && !ss_act_d_ff;
    ss_fall  = !ss_act && ss_act_d_ff;
    sck_rise = sck_s && !sck_d_ff;

    // Queue pointers and counts
    nxt_rx_wptr = qsf_ptr_next(rx_wptr_ff, rx_clear, rx_push);
    nxt_rx_rptr = qsf_ptr_next(rx_rptr_ff, rx_clear, rx_pop);
    nxt_rx_cnt  = rx_clear ? 6'h00 : qsf_cnt_next(rx_cnt_ff, rx_push, rx_pop);
    nxt_tx_wptr = qsf_ptr_next(tx_wptr_ff, tx_clear, tx_push);
    nxt_tx_rptr = qsf_ptr_next(tx_rptr_ff, tx_clear, tx_pop);
    nxt_tx_cnt  = tx_clear ? 6'h00 : qsf_cnt_next(tx_cnt_ff, tx_push, tx_pop);

    // Control fields
    nxt_rx_dma_en = wr_dma ? reg_wdata[QSF_B_RX_DMA_EN] : rx_dma_en_ff;
    nxt_rx_en     = wr_dma ? reg_wdata[QSF_B_RX_EN]     : rx_en_ff;
    nxt_rx_level  = wr_dma ? reg_wdata[QSF_B_RX_LEVEL +: 5] : rx_level_ff;
    nxt_tx_dma_en = wr_dma ? reg_wdata[QSF_B_TX_DMA_EN] : tx_dma_en_ff;
    nxt_tx_en     = wr_dma ? reg_wdata[QSF_B_TX_EN]     : tx_en_ff;
    nxt_tx_level  = wr_dma ? reg_wdata[QSF_B_TX_LEVEL +: 5] : tx_level_ff;
    nxt_even      = wr_even ? (reg_wdata[15:0] & QSF_EVT_MASK) : even_ff;
    nxt_wken      = wr_wken ? reg_wdata[3:0] : wken_ff;

    rx_thr = (rx_cnt_ff > {1'b0, rx_level_ff});
    tx_thr = (tx_cnt_ff < {1'b0, tx_level_ff});

    // Slave-mode character bit counter
    if (ss_rise) begin
      nxt_bit_cnt = 3'h0;
    end else if (ss_act && sck_rise) begin
      nxt_bit_cnt = 3'(bit_cnt_ff + 3'h1);
    end else begin
      nxt_bit_cnt = bit_cnt_ff;
    end

    // Master activity spans start to last character
    if (core_xfer_done) begin
      nxt_mbusy = 1'b0;
    end else if (core_xfer_start) begin
      nxt_mbusy = 1'b1;
    end else begin
      nxt_mbusy = mbusy_ff;
    end

    // Event sources
    ev_set                  = 16'h0000;
    ev_set[QSF_F_RX_UND]    = rd_data && rx_empty;
    ev_set[QSF_F_RX_OVR]    = !mode_master && core_rx.valid && rx_en_ff && rx_full;
    ev_set[QSF_F_TX_UND]    = !mode_master && core_tx_req && tx_empty;
    ev_set[QSF_F_TX_OVR]    = wr_data && tx_full;
    ev_set[QSF_F_M_DONE]    = mode_master && core_xfer_done;
    ev_set[QSF_F_ABORT]     = !mode_master && ss_fall && (bit_cnt_ff != 3'h0);
    ev_set[QSF_F_FAULT]     = (mode_master && multi_master_en && mm_ss_act) || core_collision;
    ev_set[QSF_F_SSD]       = ss_fall;
    ev_set[QSF_F_SSA]       = ss_rise;
    ev_set[QSF_F_RX_FULL]   = !rx_full && (nxt_rx_cnt == QSF_DEPTH);
    // A crossing seen on the count that a queue clear is removing must not survive the clear
    ev_set[QSF_F_RX_THRESH] = rx_thr && !rx_clear;
    ev_set[QSF_F_TX_EMPTY]  = !tx_empty && (nxt_tx_cnt == 6'h00);
    ev_set[QSF_F_TX_THRESH] = tx_thr && !tx_clear;

    // Software clears and queue clears; a simultaneous set wins
    ev_clr = qsf_sel16(wr_evfl, reg_wdata[15:0])
           | qsf_sel16(rx_clear, QSF_RX_FLAG_MASK)
           | qsf_sel16(tx_clear, QSF_TX_FLAG_MASK);
    nxt_evfl = ((evfl_ff & ~ev_clr) | ev_set) & QSF_EVT_MASK;

    wk_set                  = 4'h0;
    wk_set[QSF_W_RX_FULL]   = ev_set[QSF_F_RX_FULL];
    wk_set[QSF_W_RX_THRESH] = rx_thr;
    wk_set[QSF_W_TX_EMPTY]  = ev_set[QSF_F_TX_EMPTY];
    wk_set[QSF_W_TX_THRESH] = tx_thr;
    nxt_wkfl = (wkfl_ff & ~(wr_wkfl ? reg_wdata[3:0] : 4'h0)) | wk_set;

    // Registered outputs
    nxt_dma_rx_req = rx_dma_en_ff && rx_thr;
    nxt_dma_tx_req = tx_dma_en_ff && tx_thr;
    nxt_irq        = |(evfl_ff & even_ff);
    nxt_wake_req   = |(wkfl_ff & wken_ff);
    nxt_busy       = mode_master ? mbusy_ff : ss_act;
    // Master mode stalls the serial clock rather than flag an overrun or underrun
    nxt_rx_stall   = mode_master && rx_full;
    nxt_tx_stall   = mode_master && tx_empty;
    nxt_core_tx.valid = tx_pop;
    nxt_core_tx.data  = tx_pop ? tx_mem[tx_rptr_ff] : core_tx_ff.data;

    // Register read mux
    nxt_reg_rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        QSF_OFS_DATA: nxt_reg_rdata = rx_pop ? {24'h00_0000, rx_mem[rx_rptr_ff]} : 32'h0000_0000;
        QSF_OFS_DMA: begin
          nxt_reg_rdata[QSF_B_RX_DMA_EN]        = rx_dma_en_ff;
          nxt_reg_rdata[QSF_B_RX_CNT +: 6]      = rx_cnt_ff;
          nxt_reg_rdata[QSF_B_RX_EN]            = rx_en_ff;
          nxt_reg_rdata[QSF_B_RX_LEVEL +: 5]    = rx_level_ff;
          nxt_reg_rdata[QSF_B_TX_DMA_EN]        = tx_dma_en_ff;
          nxt_reg_rdata[QSF_B_TX_CNT +: 6]      = tx_cnt_ff;
          nxt_reg_rdata[QSF_B_TX_EN]            = tx_en_ff;
          nxt_reg_rdata[QSF_B_TX_LEVEL +: 5]    = tx_level_ff;
        end
        QSF_OFS_EVFL: nxt_reg_rdata = {16'h0000, evfl_ff};
        QSF_OFS_EVEN: nxt_reg_rdata = {16'h0000, even_ff};
        QSF_OFS_WKFL: nxt_reg_rdata = {28'h000_0000, wkfl_ff};
        QSF_OFS_WKEN: nxt_reg_rdata = {28'h000_0000, wken_ff};
        QSF_OFS_STAT: nxt_reg_rdata = {31'h0000_0000, busy_ff};
        default:      nxt_reg_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Queue storage writes; the data register moves one byte per access
  always_ff @(posedge core_clk) begin
    if (rx_push) begin
      rx_mem[rx_wptr_ff] <= core_rx.data;
    end
    if (tx_push) begin
      tx_mem[tx_wptr_ff] <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rx_wptr_ff    <= 5'h00;
      rx_rptr_ff    <= 5'h00;
      tx_wptr_ff    <= 5'h00;
      tx_rptr_ff    <= 5'h00;
      rx_cnt_ff     <= 6'h00;
      tx_cnt_ff     <= 6'h00;
      rx_dma_en_ff  <= 1'b0;
      rx_en_ff      <= 1'b0;
      tx_dma_en_ff  <= 1'b0;
      tx_en_ff      <= 1'b0;
      rx_level_ff   <= QSF_RX_LEVEL_RST;
      tx_level_ff   <= QSF_TX_LEVEL_RST;
      evfl_ff       <= QSF_EVFL_RST;
      even_ff       <= 16'h0000;
      wkfl_ff       <= 4'h0;
      wken_ff       <= 4'h0;
      bit_cnt_ff    <= 3'h0;
      mbusy_ff      <= 1'b0;
      reg_rdata_ff  <= 32'h0000_0000;
      core_tx_ff    <= '0;
      rx_stall_ff   <= 1'b0;
      tx_stall_ff   <= 1'b0;
      dma_rx_req_ff <= 1'b0;
      dma_tx_req_ff <= 1'b0;
      irq_ff        <= 1'b0;
      wake_req_ff   <= 1'b0;
      busy_ff       <= 1'b0;
    end else begin
      rx_wptr_ff    <= nxt_rx_wptr;
      rx_rptr_ff    <= nxt_rx_rptr;
      tx_wptr_ff    <= nxt_tx_wptr;
      tx_rptr_ff    <= nxt_tx_rptr;
      rx_cnt_ff     <= nxt_rx_cnt;
      tx_cnt_ff     <= nxt_tx_cnt;
      rx_dma_en_ff  <= nxt_rx_dma_en;
      rx_en_ff      <= nxt_rx_en;
      tx_dma_en_ff  <= nxt_tx_dma_en;
      tx_en_ff      <= nxt_tx_en;
      rx_level_ff   <= nxt_rx_level;
      tx_level_ff   <= nxt_tx_level;
      evfl_ff       <= nxt_evfl;
      even_ff       <= nxt_even;
      wkfl_ff       <= nxt_wkfl;
      wken_ff       <= nxt_wken;
      bit_cnt_ff    <= nxt_bit_cnt;
      mbusy_ff      <= nxt_mbusy;
      reg_rdata_ff  <= nxt_reg_rdata;
      core_tx_ff    <= nxt_core_tx;
      rx_stall_ff   <= nxt_rx_stall;
      tx_stall_ff   <= nxt_tx_stall;
      dma_rx_req_ff <= nxt_dma_rx_req;
      dma_tx_req_ff <= nxt_dma_tx_req;
      irq_ff        <= nxt_irq;
      wake_req_ff   <= nxt_wake_req;
      busy_ff       <= nxt_busy;
    end
  end

endmodule // qsf_core
